// ### core/lbus_pkg.sv
// Purpose: shared constants for the byte-wide local bus cycle engine
// Assumes: one PCI clock is a run of DIV core clocks (enable from divider)
// Notes: points count PCI clocks from the access request (PCI clock 0)
package lbus_pkg;
    localparam int PT_W = 5;
    typedef logic [PT_W-1:0] point_type;
    typedef logic [3:0] adj_type;

    // reference cycle: PCI clocks after initiator ready
    localparam point_type REF_PCI = 5'h02;
    // control change in the clock right after the reference cycle
    localparam point_type START_PCI = REF_PCI + 5'h01;
    // read strobe / data strobe release after reference (reads)
    localparam point_type RD_REL_PCI = REF_PCI + 5'h03;
    // write strobe / data strobe release after reference (writes)
    localparam point_type WR_REL_PCI = REF_PCI + 5'h02;
    // data bus driven again after reference (reads)
    localparam point_type REDRIVE_PCI = REF_PCI + 5'h04;
    localparam point_type PT_MIN = 5'h01;
    localparam point_type PT_MAX = 5'h1E;

    // core-clock slots inside one PCI clock: lead edges then lag edges
    localparam int SUB_W = 4;
    localparam logic [SUB_W-1:0] SUB_LEAD = 4'h1;
    localparam logic [SUB_W-1:0] SUB_LAG = 4'h2;
    // data reaches the second sync flop two core clocks after the pin
    localparam logic [SUB_W-1:0] SUB_CAP = SUB_LEAD + 4'h2;

    // adjustment fields, signed whole PCI clocks
    localparam int CFG_W = 16;
    localparam int A_SEL_ON_POS = 0;
    localparam int A_STB_ON_POS = 4;
    localparam int A_RD_OFF_POS = 8;
    localparam int A_SEL_OFF_POS = 12;
    localparam int B_WR_OFF_POS = 0;
    localparam int B_DIR_ON_POS = 4;
    localparam int B_DIR_OFF_POS = 8;
    localparam int B_REDRIVE_POS = 12;
    localparam logic [CFG_W-1:0] CFG_A_RESET = 16'h0000;
    localparam logic [CFG_W-1:0] CFG_B_RESET = 16'h0000;

    typedef enum logic {STYLE_SEPARATE, STYLE_DATA_STROBE} style_type;
endpackage

// ### core/reset_sync.sv
// Purpose: release of the active-low reset through two flip-flops
// Assumes: asynchronous assertion is fine for all downstream flops
// Notes: output goes low at once, rises two edges after the pin
`timescale 1ns/1ps
module reset_sync (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    output logic rst_n_out
);
    logic meta_r;

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta_r <= 1'b0;
            rst_n_out <= 1'b0;
        end else begin
            meta_r <= 1'b1;
            rst_n_out <= meta_r;
        end
    end
endmodule // reset_sync

// ### core/pin_sync.sv
// Purpose: two-flop synchroniser for a bus of pin inputs
// Assumes: bits are sampled only while the peripheral holds them stable
// Notes: first stage feeds the second stage only
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 8
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= pin_in;
            sync_out <= meta_r;
        end
    end
endmodule // pin_sync

// ### core/local_bus_engine.sv
// Purpose: byte-wide pass-through local bus cycles for PCI target accesses
// Assumes: req_in comes from the PCI target logic as initiator ready
// Notes: strobe points move by whole PCI clocks per the two timing words
`timescale 1ns/1ps
module local_bus_engine
#(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 8,
    parameter int DIV = 8
) (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic req_in,
    input wire logic write_in,
    input wire lbus_pkg::style_type style_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic [lbus_pkg::CFG_W-1:0] bus_timing_cfg_a_in,
    input wire logic [lbus_pkg::CFG_W-1:0] bus_timing_cfg_b_in,
    input wire logic [DATA_W-1:0] data_pin_in,
    output logic busy_out,
    output logic done_out,
    output logic [DATA_W-1:0] rdata_out,
    output logic [ADDR_W-1:0] addr_out,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe_out,
    output logic local_chip_select_n_out,
    output logic local_read_strobe_n_out,
    output logic local_write_strobe_n_out,
    output logic local_data_strobe_n_out,
    output logic local_dir_n_out
);
    import lbus_pkg::*;

    localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(DIV - 1);

    // nominal point plus signed adjustment, kept inside the counter range
    function automatic point_type shift_pt(point_type nom, adj_type adj);
        logic signed [PT_W+1:0] sum;
        sum = $signed({2'b00, nom}) + {{(PT_W-2){adj[3]}}, adj};
        if (sum < $signed({2'b00, PT_MIN}))
            return PT_MIN;
        else if (sum > $signed({2'b00, PT_MAX}))
            return PT_MAX;
        else
            return sum[PT_W-1:0];
    endfunction

    function automatic point_type max_pt(point_type a, point_type b);
        return (a > b) ? a : b;
    endfunction

    logic rst_n;
    logic [DATA_W-1:0] data_sync;
    logic run_r;
    logic [SUB_W-1:0] sub_r;
    point_type pci_r;
    logic wr_r;
    style_type style_r;
    logic [ADDR_W-1:0] addr_lat_r;
    logic [DATA_W-1:0] wdata_lat_r;
    point_type sel_on_r, stb_on_r, stb_off_r, sel_off_r;
    point_type dir_on_r, dir_off_r, redrive_r, end_r;
    point_type stb_off_nxt, sel_off_nxt, end_nxt;
    logic accept;
    logic at_end;

    reset_sync u_reset_sync (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .rst_n_out(rst_n)
    );

    pin_sync #(.W(DATA_W)) u_data_sync (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n),
        .pin_in(data_pin_in),
        .sync_out(data_sync)
    );

    function automatic logic hit(logic run, point_type pci, point_type pt,
                                 logic [SUB_W-1:0] sub,
                                 logic [SUB_W-1:0] slot);
        return run && (pci == pt) && (sub == slot);
    endfunction

    assign accept = req_in && !run_r;
    assign busy_out = run_r;
    assign at_end = run_r && (pci_r == end_r) && (sub_r == SUB_LAST);

    // release points depend on direction; end follows the latest edge
    always_comb begin
        stb_off_nxt = write_in
            ? shift_pt(WR_REL_PCI, bus_timing_cfg_b_in[B_WR_OFF_POS +: 4])
            : shift_pt(RD_REL_PCI, bus_timing_cfg_a_in[A_RD_OFF_POS +: 4]);
        sel_off_nxt = shift_pt(write_in ? WR_REL_PCI : RD_REL_PCI,
            bus_timing_cfg_a_in[A_SEL_OFF_POS +: 4]);
        end_nxt = max_pt(stb_off_nxt, sel_off_nxt);
        if (write_in)
            end_nxt = max_pt(end_nxt, shift_pt(WR_REL_PCI,
                bus_timing_cfg_b_in[B_DIR_OFF_POS +: 4]));
        else
            end_nxt = max_pt(end_nxt, shift_pt(REDRIVE_PCI,
                bus_timing_cfg_b_in[B_REDRIVE_POS +: 4]));
    end

    // latch the access and its edge points at initiator ready
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            wr_r <= 1'b0;
            style_r <= STYLE_SEPARATE;
            addr_lat_r <= '0;
            wdata_lat_r <= '0;
            sel_on_r <= START_PCI;
            stb_on_r <= START_PCI;
            stb_off_r <= RD_REL_PCI;
            sel_off_r <= RD_REL_PCI;
            dir_on_r <= START_PCI;
            dir_off_r <= WR_REL_PCI;
            redrive_r <= REDRIVE_PCI;
            end_r <= REDRIVE_PCI;
        end else if (accept) begin
            wr_r <= write_in;
            style_r <= style_in;
            addr_lat_r <= addr_in;
            wdata_lat_r <= wdata_in;
            sel_on_r <= shift_pt(START_PCI,
                bus_timing_cfg_a_in[A_SEL_ON_POS +: 4]);
            stb_on_r <= shift_pt(START_PCI,
                bus_timing_cfg_a_in[A_STB_ON_POS +: 4]);
            stb_off_r <= stb_off_nxt;
            sel_off_r <= sel_off_nxt;
            dir_on_r <= shift_pt(START_PCI,
                bus_timing_cfg_b_in[B_DIR_ON_POS +: 4]);
            dir_off_r <= shift_pt(WR_REL_PCI,
                bus_timing_cfg_b_in[B_DIR_OFF_POS +: 4]);
            redrive_r <= shift_pt(REDRIVE_PCI,
                bus_timing_cfg_b_in[B_REDRIVE_POS +: 4]);
            end_r <= end_nxt;
        end
    end

    // PCI clock divider restarts at the request; request edge is clock 0
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            run_r <= 1'b0;
            sub_r <= '0;
            pci_r <= '0;
        end else if (accept) begin
            run_r <= 1'b1;
            sub_r <= '0;
            pci_r <= '0;
        end else if (run_r) begin
            if (at_end)
                run_r <= 1'b0;
            if (sub_r == SUB_LAST) begin
                sub_r <= '0;
                pci_r <= pci_r + 5'h01;
            end else begin
                sub_r <= sub_r + 4'h1;
            end
        end
    end

    // select and address; lead slot so strobes follow one core clock later
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            local_chip_select_n_out <= 1'b1;
            addr_out <= '0;
        end else begin
            if (hit(run_r, pci_r, sel_on_r, sub_r, SUB_LEAD)) begin
                addr_out <= addr_lat_r;
                if (style_r == STYLE_SEPARATE)
                    local_chip_select_n_out <= 1'b0;
            end
            // lag slot: select rises after the strobe rose
            if (hit(run_r, pci_r, sel_off_r, sub_r, SUB_LAG))
                local_chip_select_n_out <= 1'b1;
        end
    end

    // strobes: fall in the lag slot, rise in the lead slot
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            local_read_strobe_n_out <= 1'b1;
            local_write_strobe_n_out <= 1'b1;
            local_data_strobe_n_out <= 1'b1;
        end else begin
            if (hit(run_r, pci_r, stb_on_r, sub_r, SUB_LAG)) begin
                if (style_r == STYLE_DATA_STROBE)
                    local_data_strobe_n_out <= 1'b0;
                else if (wr_r)
                    local_write_strobe_n_out <= 1'b0;
                else
                    local_read_strobe_n_out <= 1'b0;
            end
            if (hit(run_r, pci_r, stb_off_r, sub_r, SUB_LEAD)) begin
                local_read_strobe_n_out <= 1'b1;
                local_write_strobe_n_out <= 1'b1;
                local_data_strobe_n_out <= 1'b1;
            end
        end
    end

    // direction only moves for data-strobe writes
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            local_dir_n_out <= 1'b1;
        end else if (wr_r && style_r == STYLE_DATA_STROBE) begin
            if (hit(run_r, pci_r, dir_on_r, sub_r, SUB_LEAD))
                local_dir_n_out <= 1'b0;
            if (hit(run_r, pci_r, dir_off_r, sub_r, SUB_LAG))
                local_dir_n_out <= 1'b1;
        end
    end

    // data bus: written byte persists, reads float then redrive
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= '0;
            data_oe_out <= 1'b0;
        end else if (hit(run_r, pci_r, START_PCI, sub_r, SUB_LEAD)) begin
            if (wr_r) begin
                data_out <= wdata_lat_r;
                data_oe_out <= 1'b1;
            end else begin
                data_oe_out <= 1'b0;
            end
        end else if (!wr_r && hit(run_r, pci_r, redrive_r, sub_r, SUB_LEAD)) begin
            data_oe_out <= 1'b1;
        end
    end

    // pin value at the strobe rise shows at the sync output two clocks on
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rdata_out <= '0;
            done_out <= 1'b0;
        end else begin
            done_out <= at_end;
            if (!wr_r && hit(run_r, pci_r, stb_off_r, sub_r, SUB_CAP))
                rdata_out <= data_sync;
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n);

    AST_SEL_POINT: assert property (
        $fell(local_chip_select_n_out) |->
            $past(pci_r) == sel_on_r && $past(sub_r) == SUB_LEAD)
        else $error("select fell off its point");
    AST_REF_DEFAULT: assert property (
        accept && bus_timing_cfg_a_in == CFG_A_RESET |=>
            sel_on_r == REF_PCI + 5'h01)
        else $error("default select point not after reference");
    AST_CS_WRAPS_RD: assert property (
        $fell(local_read_strobe_n_out) |-> !local_chip_select_n_out
            ##1 !local_chip_select_n_out)
        else $error("read strobe fell without select");
    AST_CS_AFTER_RD: assert property (
        $rose(local_chip_select_n_out) |-> local_read_strobe_n_out
            && local_write_strobe_n_out)
        else $error("select rose under a strobe");
    AST_RD_FLOAT: assert property (
        !local_read_strobe_n_out || (!local_data_strobe_n_out && !wr_r)
            |-> !data_oe_out)
        else $error("bus driven during read strobe");
    AST_WR_DATA: assert property (
        $fell(local_write_strobe_n_out) |-> data_oe_out
            && data_out == wdata_lat_r)
        else $error("write strobe without write data");
    AST_KEEP: assert property (
        !run_r && !$past(run_r) |-> $stable(data_out)
            && $stable(data_oe_out))
        else $error("idle bus changed");
    AST_DIR_WRAP: assert property (
        !local_data_strobe_n_out && wr_r |-> !local_dir_n_out)
        else $error("data strobe write without direction");
    AST_DIR_REL: assert property (
        $rose(local_dir_n_out) |-> local_data_strobe_n_out)
        else $error("direction rose under data strobe");
    // a back-to-back request may be taken in the done cycle itself
    AST_DONE: assert property (
        done_out |-> !busy_out ##1 !done_out)
        else $error("done longer than one cycle");

    COV_SEP_READ: cover property (
        $rose(local_read_strobe_n_out) ##[1:40] done_out);
    COV_SEP_WRITE: cover property (
        $rose(local_write_strobe_n_out) ##[1:40] done_out);
    COV_DS_WRITE: cover property ($rose(local_dir_n_out));
    COV_BACK: cover property (done_out && accept);
endmodule // local_bus_engine

// ### testbench/byte_periph.sv
// Purpose: byte-wide peripheral chip behind the local bus
// Assumes: both strobe styles, one byte per access, zero data hold
// Notes: drives the bus only while its read strobe, or its data strobe with dir high, is low
`timescale 1ns/1ps
module byte_periph (
    input wire logic sep_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] bus_in,
    input wire logic cs_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic ds_n_in,
    input wire logic dir_n_in,
    output logic drive_out,
    output logic [7:0] data_out
);
    logic [7:0] mem [256];
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'hA5;
        end
    end
    // let go at the strobe rise itself: no kinder hold than required
    assign drive_out = sep_in ? (!cs_n_in && !rd_n_in)
                              : (!ds_n_in && dir_n_in);
    assign data_out = mem[addr_in];
    always @(posedge wr_n_in) begin
        if (sep_in && !cs_n_in) mem[addr_in] = bus_in;
    end
    always @(posedge ds_n_in) begin
        if (!sep_in && !dir_n_in) mem[addr_in] = bus_in;
    end
endmodule // byte_periph

// ### testbench/pci_to_8bit_local_bus_cycles_tb_top.sv
// Purpose: self-checking bench for the local bus cycle engine
// Assumes: one request at a time, next one taken in the done cycle except after the separate write
// Notes: cycle numbers count core clocks after the taken edge
`timescale 1ns/1ps
module pci_to_8bit_local_bus_cycles_tb_top;
    import lbus_pkg::*;
    localparam int DIV = 8;
    localparam int SL = 0, SH = 1, BL = 2, BH = 3;
    localparam int DL = 4, DH = 5, OE = 6, DN = 7;
    logic core_clk = 0;
    logic nrst = 0;
    logic req = 0;
    logic wr = 0;
    style_type style = STYLE_SEPARATE;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [15:0] cfg_a = 16'h0000;
    logic [15:0] cfg_b = 16'h0000;
    logic [7:0] bus, rdata, addr_o, data_o, p_data, d_stb;
    logic [7:0] last_bus = 8'h00;
    logic busy, done, oe, cs_n, rd_n, wr_n, ds_n, dir_n, p_drv, oe_stb;
    int errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    int t[8];

    local_bus_engine #(.ADDR_W(8), .DATA_W(8), .DIV(DIV)) i_local_bus_engine (
        .core_clk_in(core_clk), .nrst_in(nrst), .req_in(req),
        .write_in(wr), .style_in(style), .addr_in(addr), .wdata_in(wdata),
        .bus_timing_cfg_a_in(cfg_a), .bus_timing_cfg_b_in(cfg_b),
        .data_pin_in(bus), .busy_out(busy), .done_out(done),
        .rdata_out(rdata), .addr_out(addr_o), .data_out(data_o),
        .data_oe_out(oe), .local_chip_select_n_out(cs_n),
        .local_read_strobe_n_out(rd_n), .local_write_strobe_n_out(wr_n),
        .local_data_strobe_n_out(ds_n), .local_dir_n_out(dir_n));
    byte_periph i_byte_periph (
        .sep_in(style == STYLE_SEPARATE), .addr_in(addr_o), .bus_in(bus),
        .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n), .ds_n_in(ds_n),
        .dir_n_in(dir_n), .drive_out(p_drv), .data_out(p_data));

    // a floating bus must not keep looking like the last valid byte
    always_comb begin
        if (oe) bus = data_o;
        else if (p_drv) bus = p_data;
        else bus = ~last_bus;
    end
    always @(posedge core_clk) begin
        if (oe || p_drv) last_bus <= bus;
    end

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    task automatic conclude;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] seen, exp, input string m);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %0t: %s got %0h exp %0h", $time, m,
                     seen, exp);
        end
    endtask

    // a pin register shows its new level one clock after its slot
    function automatic int lead(int k);
        return k * DIV + SUB_LEAD + 1;
    endfunction
    function automatic int lag(int k);
        return k * DIV + SUB_LAG + 1;
    endfunction
    // done shows in the first clock after the last PCI clock
    function automatic int fin(int k);
        return (k + 1) * DIV;
    endfunction

    // one access; records the cycle of every select and direction edge, of the edges of the strobe the access uses, of the output enable rise and of done
    task automatic access(input logic w, input style_type s,
            input logic [7:0] a, d, input logic [15:0] ca, cb);
        logic ps, pb, pd, po, b;
        wr = w;
        style = s;
        addr = a;
        wdata = d;
        cfg_a = ca;
        cfg_b = cb;
        t = '{default: -1};
        req = 1;
        @(posedge core_clk);
        #1 req = 0;
        chk(busy, 1, "busy");
        ps = 1;
        pb = 1;
        pd = 1;
        po = oe;
        for (int c = 0; c < 200; c++) begin
            b = (s == STYLE_SEPARATE) ? (w ? wr_n : rd_n) : ds_n;
            if (ps && !cs_n) t[SL] = c;
            if (!ps && cs_n) t[SH] = c;
            if (pb && !b) begin
                t[BL] = c;
                d_stb = data_o;
                oe_stb = oe;
            end
            if (!pb && b) t[BH] = c;
            if (pd && !dir_n) t[DL] = c;
            if (!pd && dir_n) t[DH] = c;
            if (!po && oe) t[OE] = c;
            if (done) begin
                t[DN] = c;
                break;
            end
            ps = cs_n;
            pb = b;
            pd = dir_n;
            po = oe;
            @(posedge core_clk);
            #1;
        end
        chk(busy, 0, "busy at done");
    endtask

    task automatic t_sep_write;
        access(1, STYLE_SEPARATE, 8'h5A, 8'hC3, 16'h0000, 16'h0000);
        chk(t[SL], lead(START_PCI), "cs low");
        chk(t[BL], lag(START_PCI), "wr low");
        chk(t[BH], lead(WR_REL_PCI), "wr high");
        chk(t[SH], lag(WR_REL_PCI), "cs high");
        chk({oe_stb, d_stb}, 9'h1C3, "wdata");
        chk(t[DN], fin(WR_REL_PCI), "done");
        chk(i_byte_periph.mem[8'h5A], 8'hC3, "stored");
        repeat (4) @(posedge core_clk);
        #1;
        chk({oe, data_o}, 9'h1C3, "held");
        $display("test sep_write done");
    endtask

    task automatic t_sep_read;
        access(0, STYLE_SEPARATE, 8'h3C, 8'h00, 16'h0000, 16'h0000);
        chk(t[SL], lead(START_PCI), "cs low");
        chk(t[BL], lag(START_PCI), "rd low");
        chk(t[BH], lead(RD_REL_PCI), "rd high");
        chk(t[SH], lag(RD_REL_PCI), "cs high");
        chk(oe_stb, 0, "float");
        chk(t[OE], lead(REDRIVE_PCI), "redrive");
        chk(addr_o, 8'h3C, "addr");
        chk(rdata, 8'h3C ^ 8'hA5, "rdata");
        chk(t[DN], fin(REDRIVE_PCI), "done");
        $display("test sep_read done");
    endtask

    task automatic t_ds_write;
        access(1, STYLE_DATA_STROBE, 8'h21, 8'h7E, 16'h0000, 16'h0000);
        chk(t[DL], lead(START_PCI), "dir low");
        chk(t[BL], lag(START_PCI), "ds low");
        chk(t[BH], lead(WR_REL_PCI), "ds high");
        chk(t[DH], lag(WR_REL_PCI), "dir high");
        chk(t[SL], -1, "no cs");
        chk({oe_stb, d_stb}, 9'h17E, "wdata");
        chk(i_byte_periph.mem[8'h21], 8'h7E, "stored");
        $display("test ds_write done");
    endtask

    task automatic t_ds_read;
        access(0, STYLE_DATA_STROBE, 8'h21, 8'h00, 16'h0000, 16'h0000);
        chk(t[BL], lag(START_PCI), "ds low");
        chk(t[BH], lead(RD_REL_PCI), "ds high");
        chk(t[DL], -1, "dir kept");
        chk(oe_stb, 0, "float");
        chk(t[OE], lead(REDRIVE_PCI), "redrive");
        chk(rdata, 8'h7E, "rdata");
        $display("test ds_read done");
    endtask

    task automatic t_adjusted;
        // select earlier by one, read strobe and select release later by one
        access(0, STYLE_SEPARATE, 8'h44, 8'h00, 16'h110F, 16'h0000);
        chk(t[SL], lead(START_PCI - 1), "cs low");
        chk(t[BL], lag(START_PCI), "rd low");
        chk(t[BH], lead(RD_REL_PCI + 1), "rd high");
        chk(t[SH], lag(RD_REL_PCI + 1), "cs high");
        chk(rdata, 8'h44 ^ 8'hA5, "rdata");
        access(1, STYLE_SEPARATE, 8'h45, 8'h96, 16'h1000, 16'h0001);
        chk(t[BH], lead(WR_REL_PCI + 1), "wr high");
        chk(t[SH], lag(WR_REL_PCI + 1), "cs high");
        chk(i_byte_periph.mem[8'h45], 8'h96, "stored");
        $display("test adjusted done");
    endtask

    initial begin
        repeat (3) @(posedge core_clk);
        #1 nrst = 1;
        repeat (3) @(posedge core_clk);
        #1;
        chk({cs_n, rd_n, wr_n, ds_n, dir_n, oe, done}, 7'h7C, "idle");
        t_sep_write();
        t_sep_read();
        t_ds_write();
        t_ds_read();
        t_adjusted();
        conclude();
    end
endmodule // pci_to_8bit_local_bus_cycles_tb_top
